// File: rtl/vsc_regs_map.svh
// Register indices, field positions, reset values and timing figures of the video control bank
`ifndef VSC_REGS_MAP_SVH
`define VSC_REGS_MAP_SVH

// Register indices; byte address on the bus is four times the index
`define VSC_IDX_HSYNC_POSITION 8'h16
`define VSC_IDX_VBLANK_START 8'h18
`define VSC_IDX_VBLANK_STOP 8'h19
`define VSC_IDX_CHROMA_FIRST 8'h1a
`define VSC_IDX_CHROMA_SECOND 8'h1b
`define VSC_IDX_INT_CLEAR_B 8'h1c
`define VSC_IDX_INT_STATUS 8'h20
`define VSC_IDX_INT_MASK 8'h21
`define VSC_IDX_VIDEO_CFG 8'h22
`define VSC_BADDR(idx) ({2'b00, idx, 2'b00})

// Reset values
`define VSC_RST_HSYNC 8'h80
`define VSC_RST_VBLANK 8'h00
`define VSC_RST_AUTO_COLOR_GAIN_CTRL 2'h0
`define VSC_RST_FILT_SEL 2'h0
`define VSC_CM_DEF_525 4'h1
`define VSC_CM_DEF_625 4'h5

// Field positions
`define VSC_CC1_PLL_RST 4
`define VSC_CC1_ACE 3
`define VSC_CC1_CE 2
`define VSC_CC2_WCF 2
`define VSC_CFG_STD625 0
`define VSC_CFG_VBPIN 1

// Reference horizontal delays in sample clocks
`define VSC_HBHS_525 12'h020
`define VSC_HB_525 10'h110
`define VSC_HBHS_625 12'h018
`define VSC_HB_625 10'h11c

// Chroma output bandwidths in hertz, narrow then wide
`define VSC_BW_N0 21'h12a318
`define VSC_BW_N1 21'h0d6678
`define VSC_BW_N2 21'h0b2264
`define VSC_BW_N3 21'h079ba8
`define VSC_BW_W0 21'h159f28
`define VSC_BW_W1 21'h0fb89c
`define VSC_BW_W2 21'h0ce018
`define VSC_BW_W3 21'h0872e4

`endif

// File: rtl/vsc_pkg.sv
// Types shared by the video sync and chroma control bank
package vsc_pkg;
   // Comb filter kinds handed to the chroma path
   typedef enum logic [2:0] {
      VSC_COMB_NONE,
      VSC_COMB_3_121,
      VSC_COMB_3_101,
      VSC_COMB_4_1111,
      VSC_COMB_4_1331,
      VSC_COMB_2LINE
   } vsc_comb_t;

   // Chroma processing settings as one bundle
   typedef struct packed {
      logic adaptive;
      vsc_comb_t base;
      vsc_comb_t fallback;
      logic auto_color_gain_ctrl_enable;
      logic auto_color_gain_ctrl_freeze;
      logic [20:0] bandwidth_hz;
   } vsc_chroma_cfg_t;

   // Horizontal timing bundle
   typedef struct packed {
      logic signed [10:0] hsync_offset;
      logic signed [11:0] hsync_start;
      logic [9:0] hblank_length;
   } vsc_htiming_t;
endpackage

// File: rtl/vsc_ctrl_regs.sv
// Sync placement, vertical blank and chroma control register bank on AXI4-Lite
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
`include "vsc_regs_map.svh"

module vsc_ctrl_regs (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // AXI4-Lite slave
   input wire logic [11:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [11:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   // Decoder timing, same clock domain
   input wire logic i_line_start,
   input wire logic [9:0] i_line_num,
   input wire logic [9:0] i_std_vblank_start,
   input wire logic [9:0] i_std_vblank_stop,
   input wire logic i_luma_bypass_req,
   input wire logic [7:0] i_int_event,
   // Block outputs
   output vsc_pkg::vsc_htiming_t o_htiming,
   output vsc_pkg::vsc_chroma_cfg_t o_chroma_cfg,
   output logic o_vertical_blank_output,
   output logic o_shared_vertical_blank_pin,
   output logic o_luma_bypass_active,
   output logic o_color_loop_phase_reset,
   output logic o_subcarrier_lock_serial_out_reset,
   output logic o_irq
);

   // Register state, readable fields plus internal mode and loop reset tracking
   logic [7:0] hsync_pos_q; // Hsync placement code
   logic [7:0] vbs_adj_q; // Blank start shift
   logic [7:0] vbe_adj_q; // Blank stop shift
   logic [1:0] auto_color_gain_ctrl_q; // Colour gain field
   logic ace_q; // Adaptive comb enable
   logic ce_q; // Comb enable
   logic [3:0] cm_q; // Comb mode as written
   logic cm_written_q; // Mode written since reset
   logic wcf_q; // Wideband chroma option
   logic [1:0] filt_sel_q; // Chroma notch select
   logic std625_q; // 625-line standard selected
   logic vbpin_q; // Shared pin carries vertical blank
   logic [7:0] int_status_q; // Sticky event flags
   logic [7:0] int_mask_q; // Interrupt enables
   logic pll_rst_pend_q; // Phase reset waiting for line
   logic phase_flag_q; // Indication active this line

   // Bus channel state
   logic aw_have_q;
   logic [11:0] aw_addr_q;
   logic w_have_q;
   logic [7:0] w_data_q;
   logic w_lane0_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // Write strobes per register
   logic wr_go;
   logic wr_hit;
   logic wr_hsync;
   logic wr_vbs;
   logic wr_vbe;
   logic wr_cc1;
   logic wr_cc2;
   logic wr_iclr;
   logic wr_istat;
   logic wr_imask;
   logic wr_cfg;
   logic [7:0] int_clear;
   logic [3:0] cm_eff; // Mode in force

   // Adjusted blanking window, signed so shifts may go below zero
   logic signed [11:0] vb_start_adj;
   logic signed [11:0] vb_stop_adj;
   logic signed [11:0] line_s;
   logic in_vblank;

   // Write happens once both address and data are held and no answer is pending
   assign wr_go = aw_have_q && w_have_q && !bvalid_q;

   // Address decode; only lane 0 carries register bits
   always_comb begin
      wr_hit = 1'b1;
      wr_hsync = 1'b0;
      wr_vbs = 1'b0;
      wr_vbe = 1'b0;
      wr_cc1 = 1'b0;
      wr_cc2 = 1'b0;
      wr_iclr = 1'b0;
      wr_istat = 1'b0;
      wr_imask = 1'b0;
      wr_cfg = 1'b0;
      unique case (aw_addr_q)
         `VSC_BADDR(`VSC_IDX_HSYNC_POSITION): wr_hsync = 1'b1;
         `VSC_BADDR(`VSC_IDX_VBLANK_START): wr_vbs = 1'b1;
         `VSC_BADDR(`VSC_IDX_VBLANK_STOP): wr_vbe = 1'b1;
         `VSC_BADDR(`VSC_IDX_CHROMA_FIRST): wr_cc1 = 1'b1;
         `VSC_BADDR(`VSC_IDX_CHROMA_SECOND): wr_cc2 = 1'b1;
         `VSC_BADDR(`VSC_IDX_INT_CLEAR_B): wr_iclr = 1'b1;
         `VSC_BADDR(`VSC_IDX_INT_STATUS): wr_istat = 1'b1;
         `VSC_BADDR(`VSC_IDX_INT_MASK): wr_imask = 1'b1;
         `VSC_BADDR(`VSC_IDX_VIDEO_CFG): wr_cfg = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Clear mask from either the clear register or the status register itself
   assign int_clear = (wr_go && w_lane0_q && (wr_iclr || wr_istat)) ? w_data_q : 8'h00;

   // Mode follows the standard default until software writes it
   assign cm_eff = cm_written_q ? cm_q : (std625_q ? `VSC_CM_DEF_625 : `VSC_CM_DEF_525);

   // Bit 7 set shifts earlier; all-ones gives 128, so 127 earlier is unreachable
   function automatic logic signed [11:0] line_shift(input logic [7:0] code);
      logic [7:0] mag;
      mag = {1'b0, code[6:0]} + {7'h00, code == 8'hff};
      return code[7] ? -$signed({4'h0, mag}) : $signed({4'h0, code});
   endfunction

   // Adjusted blanking bounds
   assign vb_start_adj = {2'b00, i_std_vblank_start} + line_shift(vbs_adj_q);
   assign vb_stop_adj = {2'b00, i_std_vblank_stop} + line_shift(vbe_adj_q);
   assign line_s = {2'b00, i_line_num};
   assign in_vblank = (line_s >= vb_start_adj) && (line_s < vb_stop_adj);

   // Write address channel: one held address at a time
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 12'h000;
      end else if (i_s_axi_awvalid && o_s_axi_awready) begin
         aw_have_q <= 1'b1;
         aw_addr_q <= i_s_axi_awaddr;
      end else if (wr_go) begin
         aw_have_q <= 1'b0;
      end
   end

   // Write data channel, taken independently of the address
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         w_have_q <= 1'b0;
         w_data_q <= 8'h00;
         w_lane0_q <= 1'b0;
      end else if (i_s_axi_wvalid && o_s_axi_wready) begin
         w_have_q <= 1'b1;
         w_data_q <= i_s_axi_wdata[7:0];
         w_lane0_q <= i_s_axi_wstrb[0];
      end else if (wr_go) begin
         w_have_q <= 1'b0;
      end
   end

   // Ready only while the slot is free, so nothing is dropped
   assign o_s_axi_awready = !aw_have_q && !bvalid_q && !i_srst;
   assign o_s_axi_wready = !w_have_q && !bvalid_q && !i_srst;

   // Write response; unmapped addresses answer SLVERR
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         bvalid_q <= 1'b0;
         bresp_q <= 2'b00;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? 2'b00 : 2'b10;
      end else if (i_s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end
   assign o_s_axi_bvalid = bvalid_q;
   assign o_s_axi_bresp = bresp_q;

   // Read channel: one cycle after the address, held until rready
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= 2'b00;
      end else if (i_s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q <= 2'b00;
         rdata_q <= 32'h0000_0000;
         unique case (i_s_axi_araddr)
            `VSC_BADDR(`VSC_IDX_HSYNC_POSITION): rdata_q[7:0] <= hsync_pos_q;
            `VSC_BADDR(`VSC_IDX_VBLANK_START): rdata_q[7:0] <= vbs_adj_q;
            `VSC_BADDR(`VSC_IDX_VBLANK_STOP): rdata_q[7:0] <= vbe_adj_q;
            // Loop reset bit always reads back zero
            `VSC_BADDR(`VSC_IDX_CHROMA_FIRST): rdata_q[7:0] <= {4'h0, ace_q, ce_q, auto_color_gain_ctrl_q};
            `VSC_BADDR(`VSC_IDX_CHROMA_SECOND): rdata_q[7:0] <= {cm_eff, 1'b0, wcf_q, filt_sel_q};
            `VSC_BADDR(`VSC_IDX_INT_CLEAR_B): rdata_q[7:0] <= 8'h00;
            `VSC_BADDR(`VSC_IDX_INT_STATUS): rdata_q[7:0] <= int_status_q;
            `VSC_BADDR(`VSC_IDX_INT_MASK): rdata_q[7:0] <= int_mask_q;
            `VSC_BADDR(`VSC_IDX_VIDEO_CFG): rdata_q[7:0] <= {6'h00, vbpin_q, std625_q};
            default: rresp_q <= 2'b10;
         endcase
      end else if (i_s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign o_s_axi_arready = !rvalid_q && !i_srst;
   assign o_s_axi_rvalid = rvalid_q;
   assign o_s_axi_rdata = rdata_q;
   assign o_s_axi_rresp = rresp_q;

   // Sync placement and blanking shift registers
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         hsync_pos_q <= `VSC_RST_HSYNC;
         vbs_adj_q <= `VSC_RST_VBLANK;
         vbe_adj_q <= `VSC_RST_VBLANK;
      end else if (wr_go && w_lane0_q) begin
         if (wr_hsync) begin
            hsync_pos_q <= w_data_q;
         end
         if (wr_vbs) begin
            vbs_adj_q <= w_data_q;
         end
         if (wr_vbe) begin
            vbe_adj_q <= w_data_q;
         end
      end
   end

   // Chroma control registers
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         auto_color_gain_ctrl_q <= `VSC_RST_AUTO_COLOR_GAIN_CTRL;
         ace_q <= 1'b1;
         ce_q <= 1'b1;
         cm_q <= `VSC_CM_DEF_525;
         cm_written_q <= 1'b0;
         wcf_q <= 1'b1;
         filt_sel_q <= `VSC_RST_FILT_SEL;
      end else if (wr_go && w_lane0_q) begin
         if (wr_cc1) begin
            ace_q <= w_data_q[`VSC_CC1_ACE];
            ce_q <= w_data_q[`VSC_CC1_CE];
            auto_color_gain_ctrl_q <= w_data_q[1:0];
         end
         if (wr_cc2) begin
            cm_q <= w_data_q[7:4];
            cm_written_q <= 1'b1;
            wcf_q <= w_data_q[`VSC_CC2_WCF];
            filt_sel_q <= w_data_q[1:0];
         end
      end
   end

   // Own configuration: line standard and shared pin function
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         std625_q <= 1'b0;
         vbpin_q <= 1'b0;
      end else if (wr_go && w_lane0_q && wr_cfg) begin
         std625_q <= w_data_q[`VSC_CFG_STD625];
         vbpin_q <= w_data_q[`VSC_CFG_VBPIN];
      end
   end

   // Loop phase reset: one-cycle pulse, the bit itself is never stored
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_color_loop_phase_reset <= 1'b0;
      end else begin
         o_color_loop_phase_reset <= wr_go && w_lane0_q && wr_cc1 &&
            w_data_q[`VSC_CC1_PLL_RST];
      end
   end

   // Indication rides on the next full line; a new request beats the line start
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         pll_rst_pend_q <= 1'b0;
         phase_flag_q <= 1'b0;
      end else begin
         if (o_color_loop_phase_reset) begin
            pll_rst_pend_q <= 1'b1;
         end else if (i_line_start) begin
            pll_rst_pend_q <= 1'b0;
         end
         if (i_line_start) begin
            phase_flag_q <= pll_rst_pend_q && !o_color_loop_phase_reset;
         end
      end
   end
   assign o_subcarrier_lock_serial_out_reset = phase_flag_q;

   // Sticky status: a set in the clearing cycle wins
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         int_status_q <= 8'h00;
      end else begin
         // Bit 7 soft init, 6 copy protect, 5 command, 4 field rate, 3 alternation,
         // 2 colour lock, 1 h/v lock, 0 broadcast/tape
         int_status_q <= (int_status_q & ~int_clear) | i_int_event;
      end
   end

   // Mask register and level interrupt
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         int_mask_q <= 8'h00;
         o_irq <= 1'b0;
      end else begin
         if (wr_go && w_lane0_q && wr_imask) begin
            int_mask_q <= w_data_q;
         end
         o_irq <= |(int_status_q & int_mask_q);
      end
   end

   // Horizontal timing: offset is (0x80 - code) * 4 pixel clocks
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_htiming <= '0;
      end else begin
         o_htiming.hsync_offset <= 11'($signed({3'b000, `VSC_RST_HSYNC} - {3'b000, hsync_pos_q})
            <<< 2);
         o_htiming.hsync_start <= (std625_q ? `VSC_HBHS_625 : `VSC_HBHS_525) +
            {o_htiming.hsync_offset[10], o_htiming.hsync_offset};
         o_htiming.hblank_length <= std625_q ? `VSC_HB_625 : `VSC_HB_525;
      end
   end

   // Vertical blank and luma bypass from the adjusted window
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_vertical_blank_output <= 1'b0;
         o_shared_vertical_blank_pin <= 1'b0;
         o_luma_bypass_active <= 1'b0;
      end else begin
         o_vertical_blank_output <= in_vblank;
         o_shared_vertical_blank_pin <= vbpin_q && in_vblank;
         o_luma_bypass_active <= i_luma_bypass_req && in_vblank;
      end
   end

   // Comb selection; the reserved gain code 01 is treated as enabled
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_chroma_cfg <= '0;
      end else begin
         o_chroma_cfg.auto_color_gain_ctrl_enable <= !auto_color_gain_ctrl_q[1];
         o_chroma_cfg.auto_color_gain_ctrl_freeze <= (auto_color_gain_ctrl_q == 2'b11);
         o_chroma_cfg.adaptive <= ace_q;
         if (ace_q) begin
            // Comb enable and mode bit 3 are ignored here
            unique case (cm_eff[2:1])
               2'b00: o_chroma_cfg.base <= vsc_pkg::VSC_COMB_3_121;
               2'b01: o_chroma_cfg.base <= vsc_pkg::VSC_COMB_3_101;
               2'b10: o_chroma_cfg.base <= vsc_pkg::VSC_COMB_4_1111;
               2'b11: o_chroma_cfg.base <= vsc_pkg::VSC_COMB_4_1331;
            endcase
            o_chroma_cfg.fallback <= cm_eff[0] ? vsc_pkg::VSC_COMB_NONE :
               vsc_pkg::VSC_COMB_2LINE;
         end else begin
            o_chroma_cfg.fallback <= vsc_pkg::VSC_COMB_NONE;
            if (!ce_q) begin
               o_chroma_cfg.base <= vsc_pkg::VSC_COMB_NONE;
            end else if (cm_eff[3]) begin
               o_chroma_cfg.base <= vsc_pkg::VSC_COMB_2LINE;
            end else begin
               unique case (cm_eff[2:1])
                  2'b00: o_chroma_cfg.base <= vsc_pkg::VSC_COMB_3_121;
                  2'b01: o_chroma_cfg.base <= vsc_pkg::VSC_COMB_3_101;
                  2'b10: o_chroma_cfg.base <= vsc_pkg::VSC_COMB_4_1111;
                  2'b11: o_chroma_cfg.base <= vsc_pkg::VSC_COMB_4_1331;
               endcase
            end
         end
         // Bandwidth is the same in both standards
         unique case ({wcf_q, filt_sel_q})
            3'b000: o_chroma_cfg.bandwidth_hz <= `VSC_BW_N0;
            3'b001: o_chroma_cfg.bandwidth_hz <= `VSC_BW_N1;
            3'b010: o_chroma_cfg.bandwidth_hz <= `VSC_BW_N2;
            3'b011: o_chroma_cfg.bandwidth_hz <= `VSC_BW_N3;
            3'b100: o_chroma_cfg.bandwidth_hz <= `VSC_BW_W0;
            3'b101: o_chroma_cfg.bandwidth_hz <= `VSC_BW_W1;
            3'b110: o_chroma_cfg.bandwidth_hz <= `VSC_BW_W2;
            3'b111: o_chroma_cfg.bandwidth_hz <= `VSC_BW_W3;
         endcase
      end
   end

endmodule

// File: test/vsc_ctrl_chk.sv
// Port checks for the video control register bank
`timescale 1ns/10ps
`include "vsc_regs_map.svh"
module vsc_ctrl_chk (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic [11:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   input wire logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   input wire logic o_s_axi_wready,
   input wire logic i_line_start,
   input wire logic i_luma_bypass_req,
   input wire vsc_pkg::vsc_htiming_t o_htiming,
   input wire vsc_pkg::vsc_chroma_cfg_t o_chroma_cfg,
   input wire logic o_vertical_blank_output,
   input wire logic o_shared_vertical_blank_pin,
   input wire logic o_luma_bypass_active,
   input wire logic o_color_loop_phase_reset,
   input wire logic o_subcarrier_lock_serial_out_reset
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   // Write taken on both channels at once
   logic wr_go;
   logic [11:0] off_x;
   assign wr_go = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
   assign off_x = {o_htiming.hsync_offset[10], o_htiming.hsync_offset};
   chk_hsync_step: assert property (off_x[1:0] == 2'b00)
      else $error("hsync offset off the four-clock grid");
   // Only judged once the bundle has settled, start lags by a cycle
   chk_href_delay: assert property ($stable(o_htiming) ##1 $stable(o_htiming) |->
      (o_htiming.hblank_length == 10'h110 && o_htiming.hsync_start == off_x + 12'h020) ||
      (o_htiming.hblank_length == 10'h11c && o_htiming.hsync_start == off_x + 12'h018))
      else $error("horizontal reference delay wrong");
   chk_loop_pulse: assert property (wr_go && i_s_axi_awaddr == 12'h068 &&
      i_s_axi_wstrb[0] && i_s_axi_wdata[4] |-> ##2 o_color_loop_phase_reset)
      else $error("loop reset pulse missing");
   chk_pulse_once: assert property (o_color_loop_phase_reset |=> !o_color_loop_phase_reset)
      else $error("loop reset pulse too long");
   chk_ind_edges: assert property ($changed(o_subcarrier_lock_serial_out_reset) |->
      $past(i_line_start))
      else $error("phase indication moved off a line start");
   chk_pin_window: assert property (o_shared_vertical_blank_pin |-> o_vertical_blank_output)
      else $error("pin blank outside window");
   chk_luma_window: assert property (o_luma_bypass_active |->
      o_vertical_blank_output && $past(i_luma_bypass_req))
      else $error("luma bypass outside window");
   chk_auto_color_gain_ctrl_code: assert property (!(o_chroma_cfg.auto_color_gain_ctrl_enable && o_chroma_cfg.auto_color_gain_ctrl_freeze))
      else $error("gain both on and frozen");
   chk_fixed_fallback: assert property (!o_chroma_cfg.adaptive |->
      o_chroma_cfg.fallback == vsc_pkg::VSC_COMB_NONE)
      else $error("fixed comb with fallback");
   chk_bw_table: assert property (!$past(i_srst) |->
      o_chroma_cfg.bandwidth_hz inside {`VSC_BW_N0, `VSC_BW_N1, `VSC_BW_N2, `VSC_BW_N3,
      `VSC_BW_W0, `VSC_BW_W1, `VSC_BW_W2, `VSC_BW_W3})
      else $error("chroma bandwidth outside table");
   cov_loop: cover property (o_color_loop_phase_reset);
   cov_pin: cover property ($rose(o_shared_vertical_blank_pin));
   cov_luma: cover property (o_luma_bypass_active);
endmodule

bind vsc_ctrl_regs vsc_ctrl_chk chk_u (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
   .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid),
   .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata),
   .i_s_axi_wstrb(i_s_axi_wstrb), .i_s_axi_wvalid(i_s_axi_wvalid),
   .o_s_axi_wready(o_s_axi_wready), .i_line_start(i_line_start),
   .i_luma_bypass_req(i_luma_bypass_req), .o_htiming(o_htiming), .o_chroma_cfg(o_chroma_cfg),
   .o_vertical_blank_output(o_vertical_blank_output),
   .o_shared_vertical_blank_pin(o_shared_vertical_blank_pin),
   .o_luma_bypass_active(o_luma_bypass_active),
   .o_color_loop_phase_reset(o_color_loop_phase_reset),
   .o_subcarrier_lock_serial_out_reset(o_subcarrier_lock_serial_out_reset));

// File: test/tb_top.sv
// Self-checking bench for the video control register bank
`timescale 1ns/10ps
`include "vsc_regs_map.svh"
module tb_top;
   logic clk, srst, awv, wv, bv, br, arv, rr, ls, lreq, w, x;
   logic awr, wrdy, arr, rv, irq, vbo, pin, luma, ph, ind;
   logic [11:0] awa, ara;
   logic [31:0] wd, rd, rdv;
   logic [1:0] rres, rrs, bres, brs;
   logic [9:0] ln;
   logic [7:0] ev, c, s, t, m, x8;
   logic [15:0] lf;
   vsc_pkg::vsc_htiming_t ht;
   vsc_pkg::vsc_chroma_cfg_t cc;
   vsc_pkg::vsc_comb_t tbl[4] = '{vsc_pkg::VSC_COMB_3_121, vsc_pkg::VSC_COMB_3_101,
      vsc_pkg::VSC_COMB_4_1111, vsc_pkg::VSC_COMB_4_1331};
   logic [20:0] bw[8] = '{`VSC_BW_N0, `VSC_BW_N1, `VSC_BW_N2, `VSC_BW_N3,
      `VSC_BW_W0, `VSC_BW_W1, `VSC_BW_W2, `VSC_BW_W3};
   logic [7:0] cs[4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
   int error_cnt, check_count, cyc, pcnt, pc0, o;
   vsc_ctrl_regs dut_u (.i_clk_sys(clk), .i_srst(srst), .i_s_axi_awaddr(awa),
      .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd),
      .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy),
      .o_s_axi_bresp(bres), .o_s_axi_bvalid(bv), .i_s_axi_bready(br),
      .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
      .o_s_axi_rdata(rd), .o_s_axi_rresp(rres), .o_s_axi_rvalid(rv),
      .i_s_axi_rready(rr), .i_line_start(ls), .i_line_num(ln),
      .i_std_vblank_start(10'h12c), .i_std_vblank_stop(10'h154),
      .i_luma_bypass_req(lreq), .i_int_event(ev), .o_htiming(ht), .o_chroma_cfg(cc),
      .o_vertical_blank_output(vbo), .o_shared_vertical_blank_pin(pin),
      .o_luma_bypass_active(luma), .o_color_loop_phase_reset(ph),
      .o_subcarrier_lock_serial_out_reset(ind), .o_irq(irq));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Hang guard and loop reset pulse count
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (ph === 1'b1) pcnt <= pcnt + 1;
      if (cyc == 40000) begin
         error_cnt++;
         conclude();
      end
   end
   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // Line shift encoded in the blank registers
   function automatic int shf(input logic [7:0] v);
      if (v == 8'hff) return -128;
      return v[7] ? -int'(v[6:0]) : int'(v);
   endfunction
   // Expected base and fallback filter
   function automatic logic [5:0] xcomb(input logic a, e, input logic [3:0] q);
      if (a) return {tbl[q[2:1]], q[0] ? vsc_pkg::VSC_COMB_NONE : vsc_pkg::VSC_COMB_2LINE};
      if (!e) return {vsc_pkg::VSC_COMB_NONE, vsc_pkg::VSC_COMB_NONE};
      return {q[3] ? vsc_pkg::VSC_COMB_2LINE : tbl[q[2:1]], vsc_pkg::VSC_COMB_NONE};
   endfunction
   task automatic check(input logic [31:0] g, e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %0t: got %h want %h", $time, g, e);
      end
   endtask
   // Write: both channels offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic pa, pw, pb, sa, sw, sb;
      int n;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      pb = 1'b1;
      n = 0;
      while (pb && n < 200) begin
         @(negedge clk);
         sa = pa && awr;
         sw = pw && wrdy;
         sb = bv;
         brs = bres;
         @(posedge clk);
         if (sa) awv <= 1'b0;
         if (sw) wv <= 1'b0;
         if (sb) br <= 1'b0;
         pa = pa && !sa;
         pw = pw && !sw;
         pb = !sb;
         n++;
      end
      check(pb, 1'b0);
   endtask
   task automatic chr(input logic [11:0] a, input logic [31:0] e);
      logic pa, sa, sr;
      int n;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      pa = 1'b1;
      sr = 1'b0;
      n = 0;
      while (!sr && n < 200) begin
         @(negedge clk);
         sa = pa && arr;
         sr = rv;
         rdv = rd;
         rrs = rres;
         @(posedge clk);
         if (sa) arv <= 1'b0;
         if (sr) rr <= 1'b0;
         pa = pa && !sa;
         n++;
      end
      check(rdv, e);
   endtask
   task automatic lsp();
      @(posedge clk);
      ls <= 1'b1;
      @(posedge clk);
      ls <= 1'b0;
      @(negedge clk);
   endtask
   task automatic conclude();
      $display("Checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      {srst, awv, wv, br, arv, rr, ls, lreq} = 8'h80;
      {awa, ara, wd, ln, ev} = '0;
      lf = 16'h6d67;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      // Reset values and an unmapped place
      chr(12'h058, 32'h80);
      chr(12'h060, 32'h00);
      chr(12'h064, 32'h00);
      chr(12'h068, 32'h0c);
      chr(12'h06c, 32'h14);
      chr(12'h070, 32'h00);
      chr(12'h090, 32'h00);
      check(rrs, 2'b10);
      wr(12'h090, 32'h0);
      check(brs, 2'b10);
      wr(12'h088, 32'h1);
      check(brs, 2'b00);
      chr(12'h06c, 32'h54);
      check({cc.base, cc.fallback}, {vsc_pkg::VSC_COMB_4_1111, vsc_pkg::VSC_COMB_NONE});
      // Hsync codes at the ends and at random, both standards
      for (int i = 0; i < 12; i++) begin
         lf = nx(lf);
         c = (i < 4) ? cs[i] : lf[7:0];
         wr(12'h088, i % 2);
         wr(12'h058, c);
         repeat (3) @(posedge clk);
         o = (128 - int'(c)) * 4;
         check(ht.hsync_offset, 11'(o));
         check(ht.hsync_start, 12'(o + (i % 2 ? 24 : 32)));
         check(ht.hblank_length, i % 2 ? 10'h11c : 10'h110);
      end
      // Every comb, gain and filter code
      for (int k = 0; k < 64; k++) begin
         w = k[5] ^ k[4];
         wr(12'h068, {28'h0, k[5], k[4], k[1:0]});
         wr(12'h06c, {24'h0, k[3:0], 1'b0, w, k[3:2]});
         chr(12'h06c, {24'h0, k[3:0], 1'b0, w, k[3:2]});
         check(cc.adaptive, k[5]);
         check({cc.base, cc.fallback}, xcomb(k[5], k[4], k[3:0]));
         check({cc.auto_color_gain_ctrl_enable, cc.auto_color_gain_ctrl_freeze}, {!k[1], k[1:0] == 2'b11});
         check(cc.bandwidth_hz, bw[{w, k[3:2]}]);
      end
      // Blank window shifts, pin enable toggled
      for (int j = 0; j < 6; j++) begin
         lf = nx(lf);
         s = (j == 0) ? 8'h7f : (j == 1) ? 8'hff : lf[7:0];
         t = (j == 0) ? 8'h81 : (j == 1) ? 8'h00 : lf[15:8];
         wr(12'h088, {30'h0, j[0], 1'b0});
         wr(12'h060, s);
         wr(12'h064, t);
         for (int l = 160; l < 480; l += 5) begin
            @(posedge clk);
            ln <= l[9:0];
            lreq <= l[0];
            @(posedge clk);
            @(negedge clk);
            x = (l >= 300 + shf(s)) && (l < 340 + shf(t));
            check(vbo, x);
            check(pin, x && j[0]);
            check(luma, x && l[0]);
         end
      end
      // Loop reset pulse and the following line indication
      pc0 = pcnt;
      wr(12'h068, 32'h1c);
      repeat (2) @(posedge clk);
      check(pcnt - pc0, 1);
      chr(12'h068, 32'h0c);
      check(ind, 1'b0);
      lsp();
      check(ind, 1'b1);
      lsp();
      check(ind, 1'b0);
      // Status set by events, cleared bit by bit under a random mask
      lf = nx(lf);
      m = lf[7:0];
      wr(12'h084, m);
      @(posedge clk);
      ev <= 8'hff;
      @(posedge clk);
      ev <= 8'h00;
      for (int b = 0; b < 8; b++) begin
         x8 = 8'hff << b;
         chr(12'h080, x8);
         check(irq, |(x8 & m));
         wr(12'h070, 8'h01 << b);
      end
      chr(12'h080, 32'h00);
      check(irq, 1'b0);
      chr(12'h070, 32'h00);
      @(posedge clk);
      ev <= 8'h3c;
      @(posedge clk);
      ev <= 8'h00;
      wr(12'h080, 32'h0c);
      chr(12'h080, 32'h30);
      conclude();
   end
endmodule
